// File: src/rtc_calendar.sv
// Purpose: Calendar counters, divider readout and event flags of an RTC.
// Assumes: Avalon-MM slave, word addressed, one wait state per access.
// Notes: Busy and external event sources come from neighbouring blocks.
//
// Implementation choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "rtc_params.svh"
module rtc_calendar
  import rtc_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = `DIV_STEP_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire ext_event_s ext_events,
  input wire logic counter_busy,
  output logic irq
);

  cal_state_s s_q;
  cal_state_s s_d;
  logic [7:0] div_stage;
  logic step;
  logic soft_clear;
  logic bus_req;
  logic wr_take;
  logic [15:0] img;
  logic [15:0] wv;

  // Next BCD value of a counter that wraps from last to first.
  function automatic bcd_t bcd_next(input bcd_t v, input bcd_t last,
                                    input bcd_t first);
    bcd_t r;
    if (v == last) begin
      r = first;
    end else if (v[3:0] == 4'h9) begin
      r = {v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {v[7:4], v[3:0] + 4'h1};
    end
    return r;
  endfunction

  // Last day of the month; every year divisible by four is a leap year.
  // Only two year digits are kept, so no century rule can be applied and
  // year 00 counts as a leap year.
  function automatic bcd_t month_last(input bcd_t mon, input bcd_t yr);
    logic leap;
    bcd_t r;
    leap = (~yr[4] & (yr[3:0] == 4'h0 | yr[3:0] == 4'h4 |
            yr[3:0] == 4'h8)) | (yr[4] & (yr[3:0] == 4'h2 |
            yr[3:0] == 4'h6));
    case (mon)
      8'h02: begin
        r = leap ? 8'h29 : 8'h28;
      end
      8'h04, 8'h06, 8'h09, 8'h11: begin
        r = 8'h30;
      end
      default: begin
        r = 8'h31;
      end
    endcase
    return r;
  endfunction

  // Merge write data into an old image by byte lane; lanes 2 and 3 unused.
  // A lane left out keeps its old bits, so a byte write spares the other.
  function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = data[7:0];
    end
    if (be[1]) begin
      r[15:8] = data[15:8];
    end
    return r;
  endfunction

  // Word 0 holds seconds in 14:8 and the divider stages in 7:0.
  // Word 1 holds the half-day bit in 14, hours in 13:8, minutes in 6:0.
  // Word 2 holds the month in 12:8 and the day in 5:0.
  // Word 3 holds the weekday in 10:8 and the year in 7:0.
  // Word 4 holds the event flags, which are cleared by writing ones.
  // Word 5 holds the event enables at the same positions as the flags.
  // Word 6 holds 24-hour select in 0, soft reset in 1 and busy in 2.
  // Word 7 is unused; it reads zero and writes to it are dropped.
  // Reserved bits always read zero, so software may write back an image
  // it has read without disturbing anything except the flags of word 4, which it clears.
  // Register image as software sees it; unmapped addresses read zero.
  function automatic logic [15:0] reg_image(input cal_state_s s,
                                            input logic [2:0] a,
                                            input logic [7:0] stage,
                                            input logic busy);
    logic [15:0] r;
    r = 16'h0000;
    case (a)
      `ADDR_SEC: begin
        r[`SEC_POS +: 7] = s.t.sec[6:0];
        r[7:0] = stage;
      end
      `ADDR_HOUR: begin
        r[`HALF_DAY_POS] = s.t.half_day & ~s.mode_24_hour;
        r[`HOUR_POS +: 6] = s.t.hour[5:0];
        r[`MIN_POS +: 7] = s.t.min[6:0];
      end
      `ADDR_MONTH: begin
        r[`MONTH_POS +: 5] = s.t.month[4:0];
        r[`DAY_POS +: 6] = s.t.day[5:0];
      end
      `ADDR_YEAR: begin
        r[`WDAY_POS +: 3] = s.t.wday;
        r[`YEAR_POS +: 8] = s.t.year;
      end
      `ADDR_FLAGS: begin
        r = s.flags;
      end
      `ADDR_ENABLES: begin
        r = s.enables;
      end
      `ADDR_CTRL: begin
        r[`CTRL_MODE24_POS] = s.mode_24_hour;
        r[`CTRL_BUSY_POS] = busy;
      end
      default: begin
        r = 16'h0000;
      end
    endcase
    return r;
  endfunction

  // The divider chain; software reset restarts it from zero.
  // The clear is one cycle long and restarts the prescaler as well.
  rtc_divider #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_divider (
    .clk(clk),
    .rst_b(rst_b),
    .clear(soft_clear),
    .div_stage(div_stage),
    .step(step)
  );

  // One wait state: the first cycle of a request fetches, the second ends.
  // The acknowledge flop is rebuilt from the request every cycle, so a
  // master that gives up early leaves nothing pending behind it.
  // Writes act only in the second cycle, when the image has settled, so
  // the merge of byte lanes always starts from the current register.
  assign bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~s_q.ack;
  assign wr_take = avs_write & s_q.ack;
  assign avs_readdata = s_q.rdata;
  assign irq = s_q.irq;
  assign img = reg_image(s_q, avs_address, div_stage, counter_busy);
  assign wv = lane_merge(img, avs_writedata, avs_byteenable);
  assign soft_clear = wr_take & (avs_address == `ADDR_CTRL) &
                      wv[`CTRL_SRST_POS];

  // Counting, event detection and register writes. A write in the same
  // cycle as a carry overrides the counted value; software is expected
  // to avoid writing while busy, so this only matters for misuse.
  always_comb begin
    logic [15:0] ev;
    logic [15:0] clr;
    logic sec_tick;
    logic min_tick;
    logic hour_tick;
    logic day_tick;
    bcd_t last_day;
    s_d = s_q;
    ev = 16'h0000;
    clr = 16'h0000;
    min_tick = 1'b0;
    hour_tick = 1'b0;
    day_tick = 1'b0;
    last_day = month_last(s_q.t.month, s_q.t.year);
    sec_tick = step & (div_stage == 8'hFF);
    s_d.ack = bus_req & ~s_q.ack;

    // Sub-second events fire as the low stages wrap.
    // The second event is the wrap of the whole stage byte, so every
    // sub-second flag fires on that same step as well.
    ev[`FLG_HALF] = step & (div_stage[6:0] == 7'h7F);
    ev[`FLG_QUARTER] = step & (div_stage[5:0] == 6'h3F);
    ev[`FLG_EIGHTH] = step & (div_stage[4:0] == 5'h1F);
    ev[`FLG_T32] = step & (div_stage[2:0] == 3'h7);
    ev[`FLG_SECOND] = sec_tick;

    // Seconds and minutes ripple on their 59 to 00 wrap.
    if (sec_tick) begin
      s_d.t.sec = bcd_next(s_q.t.sec, 8'h59, 8'h00);
      min_tick = (s_q.t.sec == 8'h59);
    end
    if (min_tick) begin
      s_d.t.min = bcd_next(s_q.t.min, 8'h59, 8'h00);
      hour_tick = (s_q.t.min == 8'h59);
    end

    // Hours follow the selected mode.
    // In 12-hour mode the half-day bit flips on the 11 to 12 step, and a
    // new day starts only when it flips back from afternoon to morning.
    // In 24-hour mode a stale afternoon bit is dropped on this increment
    // and not on the mode change; reads mask it until then.
    if (hour_tick) begin
      if (s_q.mode_24_hour) begin
        s_d.t.hour = bcd_next(s_q.t.hour, 8'h23, 8'h00);
        s_d.t.half_day = 1'b0;
        day_tick = (s_q.t.hour == 8'h23);
      end else begin
        s_d.t.hour = bcd_next(s_q.t.hour, 8'h12, 8'h01);
        if (s_q.t.hour == 8'h11) begin
          s_d.t.half_day = ~s_q.t.half_day;
          day_tick = s_q.t.half_day;
        end
      end
    end

    // Day, weekday, month and year.
    // The weekday only follows the day counter and knows nothing of the
    // date, so software must load the two consistently.
    if (day_tick) begin
      s_d.t.day = bcd_next(s_q.t.day, last_day, 8'h01);
      s_d.t.wday = (s_q.t.wday == `WDAY_LAST) ? 3'h0 :
                   s_q.t.wday + 3'h1;
      if (s_q.t.day == last_day) begin
        s_d.t.month = bcd_next(s_q.t.month, 8'h12, 8'h01);
        if (s_q.t.month == 8'h12) begin
          s_d.t.year = bcd_next(s_q.t.year, 8'h99, 8'h00);
        end
      end
    end
    ev[`FLG_MINUTE] = min_tick;
    ev[`FLG_HOUR] = hour_tick;
    ev[`FLG_DAY] = day_tick;

    // Events from neighbouring blocks.
    ev[`FLG_REGULATION] = ext_events.regulation_done;
    ev[`FLG_SW_1HZ] = ext_events.stopwatch_1hz;
    ev[`FLG_SW_10HZ] = ext_events.stopwatch_10hz;
    ev[`FLG_SW_100HZ] = ext_events.stopwatch_100hz;
    ev[`FLG_ALARM] = ext_events.alarm_match;

    // Register writes take effect at the edge where waitrequest is low.
    if (wr_take) begin
      case (avs_address)
        `ADDR_SEC: begin
          s_d.t.sec = {1'b0, wv[`SEC_POS +: 7]};
        end
        `ADDR_HOUR: begin
          s_d.t.half_day = wv[`HALF_DAY_POS] &
                           ~s_q.mode_24_hour;
          s_d.t.hour = {2'b00, wv[`HOUR_POS +: 6]};
          s_d.t.min = {1'b0, wv[`MIN_POS +: 7]};
        end
        `ADDR_MONTH: begin
          s_d.t.month = {3'b000, wv[`MONTH_POS +: 5]};
          s_d.t.day = {2'b00, wv[`DAY_POS +: 6]};
        end
        `ADDR_YEAR: begin
          s_d.t.wday = wv[`WDAY_POS +: 3];
          s_d.t.year = wv[`YEAR_POS +: 8];
        end
        `ADDR_FLAGS: begin
          // A lane left out of byteenable clears nothing, whatever its data.
          clr = avs_writedata[15:0];
          if (!avs_byteenable[0]) begin
            clr[7:0] = 8'h00;
          end
          if (!avs_byteenable[1]) begin
            clr[15:8] = 8'h00;
          end
        end
        `ADDR_ENABLES: begin
          // Reserved positions are masked so they always read back zero.
          s_d.enables = wv & `FLAG_MASK;
        end
        `ADDR_CTRL: begin
          s_d.mode_24_hour = wv[`CTRL_MODE24_POS];
        end
        default: begin
          s_d.enables = s_q.enables;
        end
      endcase
    end

    // A new event wins over a clear in the same cycle.
    s_d.flags = ((s_q.flags & ~clr) | ev) & `FLAG_MASK;
    // The request follows the next flags and enables, so it rises on the
    // same edge as the flag that causes it.
    s_d.irq = |(s_d.flags & s_d.enables);

    // Read data is fetched in the wait cycle and stands in the next.
    if (avs_read & ~s_q.ack) begin
      s_d.rdata = {16'h0000, img};
    end
  end

  // State register. Hour 12, day 1 and month 1 are the only non-zero
  // reset values; acknowledge and read data start at zero, so the bus
  // stays quiet while reset is held.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_q <= '0;
      s_q.t.hour <= `HOUR_RST;
      s_q.t.month <= `MONTH_RST;
      s_q.t.day <= `DAY_RST;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// File: src/rtc_params.svh
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: Included by bare name; definitions only.
// Notes: Register offsets are word indices on the Avalon-MM slave.
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH

// Clock and divider step rate; the stage counter advances at 256 Hz.
`define CLK_HZ 40000000
`define DIV_STEP_HZ 256
`define DIV_STEP_CYCLES (`CLK_HZ / `DIV_STEP_HZ)

// Word indices of the registers.
`define ADDR_SEC 3'h0
`define ADDR_HOUR 3'h1
`define ADDR_MONTH 3'h2
`define ADDR_YEAR 3'h3
`define ADDR_FLAGS 3'h4
`define ADDR_ENABLES 3'h5
`define ADDR_CTRL 3'h6

// Field positions inside the 16-bit register images.
`define SEC_POS 8
`define HALF_DAY_POS 14
`define HOUR_POS 8
`define MIN_POS 0
`define MONTH_POS 8
`define DAY_POS 0
`define WDAY_POS 8
`define YEAR_POS 0
`define CTRL_MODE24_POS 0
`define CTRL_SRST_POS 1
`define CTRL_BUSY_POS 2

// Flag and enable bit positions.
`define FLG_REGULATION 15
`define FLG_SW_1HZ 14
`define FLG_SW_10HZ 13
`define FLG_SW_100HZ 12
`define FLG_ALARM 8
`define FLG_DAY 7
`define FLG_HOUR 6
`define FLG_MINUTE 5
`define FLG_SECOND 4
`define FLG_HALF 3
`define FLG_QUARTER 2
`define FLG_EIGHTH 1
`define FLG_T32 0
`define FLAG_MASK 16'hF1FF

// Reset values of the calendar counters and the last weekday value.
`define HOUR_RST 8'h12
`define MONTH_RST 8'h01
`define DAY_RST 8'h01
`define WDAY_LAST 3'h6

`endif

// File: src/rtc_pkg.sv
// Purpose: Types shared by the real-time clock design files.
// Assumes: Nothing beyond the parameter header.
// Notes: Calendar digits are packed BCD, tens in the upper nibble.
package rtc_pkg;

  typedef logic [7:0] bcd_t;

  // Event pulses arriving from the neighbouring RTC blocks.
  typedef struct packed {
    logic regulation_done;
    logic stopwatch_1hz;
    logic stopwatch_10hz;
    logic stopwatch_100hz;
    logic alarm_match;
  } ext_event_s;

  // Time of day and calendar.
  typedef struct packed {
    bcd_t sec;
    bcd_t min;
    bcd_t hour;
    logic half_day;
    bcd_t day;
    bcd_t month;
    bcd_t year;
    logic [2:0] wday;
  } cal_s;

  // Whole state of the divider module.
  typedef struct packed {
    logic [31:0] pre;
    logic [7:0] stage;
  } div_state_s;

  // Whole state of the calendar module.
  typedef struct packed {
    cal_s t;
    logic [15:0] flags;
    logic [15:0] enables;
    logic mode_24_hour;
    logic ack;
    logic [31:0] rdata;
    logic irq;
  } cal_state_s;

endpackage

// File: src/rtc_divider.sv
// Purpose: Prescaler and eight-stage sub-second divider chain.
// Assumes: One clock; clear is a one-cycle pulse from software.
// Notes: Stage bit 0 toggles at 256 Hz steps, giving a 128 Hz square.
`timescale 1ns/1ps
`include "rtc_params.svh"
module rtc_divider
  import rtc_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = `DIV_STEP_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clear,
  output logic [7:0] div_stage,
  output logic step
);

  div_state_s s_q;
  div_state_s s_d;

  // Step is combinational so the calendar sees it with the old stage.
  assign step = (s_q.pre == 32'(STEP_CYCLES - 1)) & ~clear;
  assign div_stage = s_q.stage;

  // Prescaler counts clock cycles; a clear restarts the whole chain.
  always_comb begin
    s_d = s_q;
    if (clear) begin
      s_d.pre = 32'h0;
      s_d.stage = 8'h00;
    end else if (step) begin
      s_d.pre = 32'h0;
      s_d.stage = s_q.stage + 8'h01;
    end else begin
      s_d.pre = s_q.pre + 32'h1;
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// File: testbench/rtc_calendar_sva.sv
// Purpose: Concurrent checks on the calendar register slave.
// Assumes: One clock, synchronous active-low reset, one wait state.
// Notes: Mode and alarm enable are shadowed from completed writes.
`timescale 1ns/1ps
`include "rtc_params.svh"
module rtc_calendar_sva
  import rtc_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire ext_event_s ext_events,
  input wire logic counter_busy,
  input wire logic irq
);
  logic m24_q;
  logic en8_q;
  logic wr_done;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // Reserved bits per word; unmapped words read all zero.
  function automatic logic [15:0] resv(input logic [2:0] a);
    case (a)
      3'h0: return 16'h8000;
      3'h1: return 16'h8080;
      3'h2: return 16'hE0C0;
      3'h3: return 16'hF800;
      3'h4: return 16'h0E00;
      3'h5: return 16'h0E00;
      3'h6: return 16'hFFFA;
      default: return 16'hFFFF;
    endcase
  endfunction

  sequence rd_at(logic [2:0] a);
    avs_read && !avs_waitrequest && avs_address == a;
  endsequence

  assign wr_done = avs_write && !avs_waitrequest;

  // Shadows follow the completing edge, the same edge the slave uses.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      m24_q <= 1'b0;
      en8_q <= 1'b0;
    end else begin
      if (wr_done && avs_address == `ADDR_CTRL && avs_byteenable[0]) begin
        m24_q <= avs_writedata[0];
      end
      if (wr_done && avs_address == `ADDR_ENABLES && avs_byteenable[1]) begin
        en8_q <= avs_writedata[8];
      end
    end
  end

  AST_WAIT_FIRST: assert property (($rose(avs_read) || $rose(avs_write))
    |-> avs_waitrequest) else $error("request answered without wait");
  AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("wait state longer than one");
  AST_RESERVED: assert property (avs_read && !avs_waitrequest |->
    ((avs_readdata[15:0] & resv(avs_address)) == 16'h0000)
    && avs_readdata[31:16] == 16'h0000) else $error("reserved bits set");
  AST_SEC_BCD: assert property (rd_at(`ADDR_SEC) |->
    avs_readdata[14:12] <= 3'h5 && avs_readdata[11:8] <= 4'h9)
    else $error("seconds out of range");
  AST_HM_BCD: assert property (rd_at(`ADDR_HOUR) |->
    avs_readdata[13:12] <= 2'h2 && avs_readdata[11:8] <= 4'h9
    && avs_readdata[6:4] <= 3'h5 && avs_readdata[3:0] <= 4'h9)
    else $error("hour or minute out of range");
  AST_HALF_24: assert property (rd_at(`ADDR_HOUR) and m24_q |->
    !avs_readdata[14]) else $error("half day set in 24 hour mode");
  AST_MON_DAY: assert property (rd_at(`ADDR_MONTH) |->
    avs_readdata[12:8] != 5'h00 && avs_readdata[12:8] <= 5'h12
    && avs_readdata[11:8] <= 4'h9 && avs_readdata[5:0] != 6'h00
    && avs_readdata[3:0] <= 4'h9) else $error("month or day out of range");
  AST_YEAR_WDAY: assert property (rd_at(`ADDR_YEAR) |->
    avs_readdata[10:8] <= 3'h6 && avs_readdata[7:4] <= 4'h9
    && avs_readdata[3:0] <= 4'h9) else $error("year or weekday bad");
  AST_IRQ_ALARM: assert property (ext_events.alarm_match && en8_q
    |-> ##[1:2] irq) else $error("enabled alarm gave no irq");
  AST_IRQ_OFF: assert property (wr_done && avs_address == `ADDR_ENABLES
    && avs_byteenable[1:0] == 2'h3 && avs_writedata[15:0] == 16'h0000
    |-> ##[1:2] !irq) else $error("irq high with all enables off");
endmodule

bind rtc_calendar rtc_calendar_sva #(.STEP_CYCLES(STEP_CYCLES)) i_sva (
  .clk(clk),
  .rst_b(rst_b),
  .avs_address(avs_address),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .ext_events(ext_events),
  .counter_busy(counter_busy),
  .irq(irq)
);

// File: testbench/rtc_calendar_bench.sv
// Purpose: Register-level tests of the calendar block.
// Assumes: Short divider step so one second is 1024 clocks.
// Notes: Writes are placed just after a second tick to avoid racing it.
`timescale 1ns/1ps
`include "rtc_params.svh"
module rtc_calendar_bench
  import rtc_pkg::*;
();
  localparam int unsigned STEP = 4;
  logic clk;
  logic rst_b;
  logic [2:0] addr;
  logic rd_s;
  logic wr_s;
  logic [31:0] wdata;
  logic [3:0] be;
  logic [31:0] rdata;
  logic wait_s;
  ext_event_s ev;
  logic busy;
  logic irq;
  logic [15:0] v;
  logic [15:0] u;
  int errors;
  int checks;
  int cycles;
  int pos [5] = '{8, 12, 13, 14, 15};

  rtc_calendar #(.STEP_CYCLES(STEP)) i_rtc_calendar (
    .clk(clk),
    .rst_b(rst_b),
    .avs_address(addr),
    .avs_read(rd_s),
    .avs_write(wr_s),
    .avs_writedata(wdata),
    .avs_byteenable(be),
    .avs_readdata(rdata),
    .avs_waitrequest(wait_s),
    .ext_events(ev),
    .counter_busy(busy),
    .irq(irq)
  );

  always #12.5 clk = ~clk;

  task automatic conclude();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // A hang is cut short well after the four second waits.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 12000) begin
      errors = errors + 1;
      conclude();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One bus cycle; the request is held until waitrequest is seen low.
  task automatic xfer(input logic w, input logic [2:0] a,
                      input logic [15:0] d, input logic [3:0] b);
    @(posedge clk);
    addr <= a;
    wdata <= {16'h0000, d};
    be <= b;
    wr_s <= w;
    rd_s <= !w;
    do @(posedge clk); while (wait_s !== 1'b0);
    v = rdata[15:0];
    wr_s <= 1'b0;
    rd_s <= 1'b0;
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    xfer(1'b1, a, d, 4'h3);
  endtask

  task automatic rc(input logic [2:0] a, input logic [15:0] m,
                    input logic [15:0] e);
    xfer(1'b0, a, 16'h0000, 4'h0);
    chk(v & m, e);
  endtask

  // Clears every flag, then polls until the next second tick lands.
  task automatic tick();
    wr(`ADDR_FLAGS, 16'hFFFF);
    do xfer(1'b0, `ADDR_FLAGS, 16'h0000, 4'h0); while (v[4] !== 1'b1);
  endtask

  task automatic pulse(input int k);
    @(posedge clk);
    ev <= ext_event_s'(5'h01 << k);
    @(posedge clk);
    ev <= '0;
  endtask

  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    addr = 3'h0;
    rd_s = 1'b0;
    wr_s = 1'b0;
    wdata = 32'h0;
    be = 4'h0;
    ev = '0;
    busy = 1'b0; // Calendar writes happen only while idle
    errors = 0;
    checks = 0;
    cycles = 0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    rc(`ADDR_FLAGS, 16'hFFFF, 16'h0000);
    rc(`ADDR_ENABLES, 16'hFFFF, 16'h0000);
    rc(`ADDR_HOUR, 16'hFFFF, 16'h1200);
    rc(`ADDR_MONTH, 16'hFFFF, 16'h0101);
    rc(`ADDR_YEAR, 16'hFFFF, 16'h0000);
    rc(`ADDR_SEC, 16'hFF00, 16'h0000);
    rc(3'h7, 16'hFFFF, 16'h0000);
    $display("test reset values done");
    wr(`ADDR_HOUR, 16'h5159);
    rc(`ADDR_HOUR, 16'hFFFF, 16'h5159);
    xfer(1'b1, `ADDR_HOUR, 16'h0030, 4'h1);
    rc(`ADDR_HOUR, 16'hFFFF, 16'h5130);
    $display("test lanes done");
    tick();
    wr(`ADDR_HOUR, 16'h5159);
    wr(`ADDR_MONTH, 16'h1231); // Month is never loaded with zero
    wr(`ADDR_YEAR, 16'h0699);
    xfer(1'b1, `ADDR_SEC, 16'h5900, 4'h2);
    tick();
    rc(`ADDR_SEC, 16'hFF00, 16'h0000);
    rc(`ADDR_HOUR, 16'hFFFF, 16'h1200);
    rc(`ADDR_MONTH, 16'hFFFF, 16'h0101);
    rc(`ADDR_YEAR, 16'hFFFF, 16'h0000);
    rc(`ADDR_FLAGS, 16'h00F0, 16'h00F0);
    $display("test year rollover done");
    wr(`ADDR_HOUR, 16'h4859);
    wr(`ADDR_CTRL, 16'h0001);
    rc(`ADDR_HOUR, 16'hFFFF, 16'h0859);
    wr(`ADDR_CTRL, 16'h0000);
    rc(`ADDR_HOUR, 16'hFFFF, 16'h4859);
    wr(`ADDR_CTRL, 16'h0001);
    xfer(1'b1, `ADDR_SEC, 16'h5900, 4'h2);
    tick();
    rc(`ADDR_HOUR, 16'hFFFF, 16'h0900);
    wr(`ADDR_CTRL, 16'h0000);
    rc(`ADDR_HOUR, 16'hFFFF, 16'h0900);
    $display("test half day done");
    wr(`ADDR_CTRL, 16'h0001);
    wr(`ADDR_HOUR, 16'h2359);
    wr(`ADDR_MONTH, 16'h0228);
    wr(`ADDR_YEAR, 16'h0324);
    xfer(1'b1, `ADDR_SEC, 16'h5900, 4'h2);
    tick();
    rc(`ADDR_HOUR, 16'hFFFF, 16'h0000);
    rc(`ADDR_MONTH, 16'hFFFF, 16'h0229);
    rc(`ADDR_YEAR, 16'hFFFF, 16'h0424);
    $display("test leap day done");
    wr(`ADDR_ENABLES, 16'hFFFF);
    rc(`ADDR_ENABLES, 16'hFFFF, 16'hF1FF);
    wr(`ADDR_ENABLES, 16'h0100);
    wr(`ADDR_FLAGS, 16'hFFFF);
    @(posedge clk);
    chk({15'h0, irq}, 16'h0000);
    for (int k = 0; k < 5; k++) begin
      pulse(k);
      rc(`ADDR_FLAGS, 16'h1 << pos[k], 16'h1 << pos[k]);
    end
    chk({15'h0, irq}, 16'h0001);
    wr(`ADDR_FLAGS, 16'h0000);
    rc(`ADDR_FLAGS, 16'hF100, 16'hF100);
    wr(`ADDR_FLAGS, 16'h0100);
    @(posedge clk);
    chk({15'h0, irq}, 16'h0000);
    wr(`ADDR_ENABLES, 16'h0000);
    $display("test flags done");
    busy <= 1'b1;
    rc(`ADDR_CTRL, 16'h0004, 16'h0004);
    busy <= 1'b0;
    wr(`ADDR_CTRL, 16'h0002);
    xfer(1'b0, `ADDR_SEC, 16'h0000, 4'h0);
    chk({9'h0, v[7:1]}, 16'h0000);
    // Half a second after the clear only the 1 Hz stage is set, and the
    // stage holds that value across both reads of the pair.
    repeat (127 * STEP) @(posedge clk);
    do begin
      xfer(1'b0, `ADDR_SEC, 16'h0000, 4'h0);
      u = v;
      xfer(1'b0, `ADDR_SEC, 16'h0000, 4'h0);
    end while (u[7:0] !== v[7:0]);
    chk({8'h00, v[7:0]}, 16'h0080);
    $display("test soft reset done");
    conclude();
  end
endmodule
